/* File: safety_switch.sv */
/*
 * Model of the external safety switch that drives both channels.
 * Assumes the bench commands it away from the rising edge of CLK.
 */
`default_nettype none
module safety_switch #(
    parameter int PULSE_CYC = 4   // Dip length, kept below the filter span
) (
    input  wire logic CLK,        // Bench clock
    input  wire logic open_a,     // Hold channel A open
    input  wire logic open_b,     // Hold channel B open
    input  wire logic test_pulse, // Start a diagnostic dip on both
    output logic      ch_a,       // Channel A, high = current flows
    output logic      ch_b        // Channel B, high = current flows
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned left = 0;
    // A dip ends by itself, so it never passes for a real stop.
    // Sampled on the rising edge so a falling-edge bench change never races it.
    always @(posedge CLK) begin
        if (test_pulse && left == 0) left <= PULSE_CYC;
        else if (left != 0) left <= left - 1;
    end
    // Open commands are held by the bench far beyond the filter
    assign ch_a = !(open_a || left != 0);
    assign ch_b = !(open_b || left != 0);
endmodule
`default_nettype wire

/* File: tb_dual_channel_torque_cutoff.sv */
/*
 * Self-checking bench for the torque cutoff monitor.
 * Assumes short filter and mismatch counts set at the instance.
 */
`default_nettype none
module tb_dual_channel_torque_cutoff;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic SERVO_ON = 1'b0;
    logic CUTOFF_CIRCUIT_FAULT = 1'b0;
    logic open_a = 1'b0;
    logic open_b = 1'b0;
    logic test_pulse = 1'b0;
    logic ch_a, ch_b, enable, ready, mis, sf;
    int fail_count = 0;
    int cmp_count = 0;

    always #5 CLK = ~CLK;

    safety_switch sw (.CLK(CLK), .open_a(open_a), .open_b(open_b),
        .test_pulse(test_pulse), .ch_a(ch_a), .ch_b(ch_b));
    torque_cutoff #(.FILTER_CYC(8), .MISMATCH_CYC(40)) dut (.CLK(CLK), .RESETN(RESETN),
        .SAFETY_CHANNEL_A(ch_a), .SAFETY_CHANNEL_B(ch_b), .SERVO_ON(SERVO_ON),
        .CUTOFF_CIRCUIT_FAULT(CUTOFF_CIRCUIT_FAULT), .POWER_STAGE_ENABLE(enable),
        .READY(ready), .CHANNEL_MISMATCH_ALARM(mis), .SINGLE_FAULT_ALARM(sf));

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge CLK);
    endtask
    task automatic do_reset();
        RESETN = 1'b0;
        cyc(4);
        RESETN = 1'b1;
    endtask
    task automatic t_ready_run();
        cyc(6);
        chk(ready, 1'b1, "not ready with both on");
        chk(enable, 1'b0, "torque before servo-on");
        SERVO_ON = 1'b1;
        cyc(2);
        chk(enable, 1'b1, "servo-on did not run");
        SERVO_ON = 1'b0;
        cyc(2);
        chk(enable, 1'b0, "servo-off still runs");
        chk(ready, 1'b1, "servo-off left ready");
    endtask
    task automatic t_pulse_cut();
        SERVO_ON = 1'b1;
        cyc(2);
        test_pulse = 1'b1;
        cyc(1);
        test_pulse = 1'b0;
        cyc(20);
        chk(enable, 1'b1, "test dip cut torque");
        chk(mis, 1'b0, "test dip raised alarm");
        {open_a, open_b} = 2'b11;
        cyc(16);
        chk(enable, 1'b0, "no cutoff while running");
        chk(ready, 1'b0, "ready in cutoff");
        SERVO_ON = 1'b0;
        {open_a, open_b} = 2'b00;
        cyc(6);
        chk(ready, 1'b1, "cutoff not left");
    endtask
    task automatic t_mismatch();
        open_a = 1'b1;
        cyc(40);
        chk(mis, 1'b0, "alarm too early");
        chk(enable, 1'b0, "torque with one channel open");
        cyc(30);
        chk(mis, 1'b1, "alarm missing");
        open_a = 1'b0;
        cyc(10);
        chk(mis, 1'b1, "alarm cleared by agreement");
    endtask
    task automatic t_fault();
        do_reset();
        chk(mis, 1'b0, "alarm survived power cycle");
        cyc(6);
        SERVO_ON = 1'b1;
        cyc(2);
        CUTOFF_CIRCUIT_FAULT = 1'b1;
        cyc(8);
        CUTOFF_CIRCUIT_FAULT = 1'b0;
        chk(sf, 1'b1, "fault alarm missing");
        chk(enable, 1'b0, "torque despite fault");
        chk(ready, 1'b0, "ready despite fault");
        cyc(4);
        chk(sf, 1'b1, "fault alarm not held");
    endtask

    // Whole run is under two hundred cycles; a hang is cut well after that
    initial begin
        #20us;
        fail_count++;
        tally_and_finish();
    end
    initial begin
        cyc(1);
        do_reset();
        t_ready_run();
        t_pulse_cut();
        t_mismatch();
        t_fault();
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: torque_cutoff.sv */
/*
 * Dual-channel torque cutoff monitor: filters two redundant safety inputs,
 * drives the power stage enable, and latches a channel mismatch alarm.
 * Assumes channel pins are asynchronous and high while current flows (on).
 * Only RESETN (power-up) clears the latched alarms.
 */
`default_nettype none
// Notes on behaviour
// R1: Both channels off: cut output, coast.
// R2: Both channels on: leave cutoff, await servo-on.
// R3: Channels off while running: cutoff immediately.
// R4: Mismatch longer than 50 ms raises alarm.
// R5: Mismatch alarm latched until power cycle.
// R6: Internal single fault: alarm and cut output.
// R7: External test pulses shorter than 1 ms.
// R8: External holds channels off at least 20 ms.
// R9: Diagnostic toggles held at least 2 s.
// R10: Cutoff completes within 50 ms of off.
// R11: Servo-on runs; servo-off returns to ready.
// R12: Filter off pulses shorter than test pulse.
module torque_cutoff #(
    parameter int FILTER_CYC   = torque_cutoff_pkg::FILTER_CYCLES,
    parameter int MISMATCH_CYC = torque_cutoff_pkg::MISMATCH_CYCLES
) (
    input  wire logic CLK,                      // 100 MHz clock
    input  wire logic RESETN,                   // Power-up reset, active low
    input  wire logic SAFETY_CHANNEL_A,         // Safety input A, high = on
    input  wire logic SAFETY_CHANNEL_B,         // Safety input B, high = on
    input  wire logic SERVO_ON,                 // Servo-on command, high = on
    input  wire logic CUTOFF_CIRCUIT_FAULT,     // Internal fault detector, high = fault
    output logic      POWER_STAGE_ENABLE,       // Gate drive enable, high = torque
    output logic      READY,                    // Ready for operation
    output logic      CHANNEL_MISMATCH_ALARM,   // Latched mismatch alarm
    output logic      SINGLE_FAULT_ALARM        // Latched cutoff circuit fault alarm
);
    localparam int CW = torque_cutoff_pkg::CNT_W;

    logic [1:0]   sync1;
    logic [1:0]   sync2;
    logic         fsync1;
    logic         fsync2;
    logic [1:0]   filt;
    logic [CW-1:0] off_cnt [2];
    logic [CW-1:0] mis_cnt;
    logic [CW-1:0] off_age;
    torque_cutoff_pkg::drive_state_t state;
    torque_cutoff_pkg::drive_state_t next_state;
    logic         both_on;
    logic         both_off;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sync1  <= 2'h0;
            sync2  <= 2'h0;
            fsync1 <= 1'b0;
            fsync2 <= 1'b0;
        end else begin
            sync1  <= {SAFETY_CHANNEL_B, SAFETY_CHANNEL_A};
            sync2  <= sync1;
            fsync1 <= CUTOFF_CIRCUIT_FAULT;
            fsync2 <= fsync1;
        end
    end

    // An on level passes at once; an off level must outlast a test pulse.
    // This delays the cutoff by 1 ms, well inside the 50 ms response budget.
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_filter
            always_ff @(posedge CLK or negedge RESETN) begin
                if (!RESETN) begin
                    off_cnt[g] <= '0;
                    filt[g]    <= 1'b0;
                end else if (sync2[g]) begin
                    off_cnt[g] <= '0;
                    filt[g]    <= 1'b1;
                end else if (off_cnt[g] >= CW'(FILTER_CYC)) begin
                    filt[g]    <= 1'b0;                         // see R12
                end else begin
                    off_cnt[g] <= off_cnt[g] + CW'(1);
                end
            end
        end
    endgenerate

    assign both_on  = filt[0] & filt[1];
    assign both_off = ~filt[0] & ~filt[1];

    // Mismatch timer runs on filtered levels so test pulses are not counted
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mis_cnt                <= '0;
            CHANNEL_MISMATCH_ALARM <= 1'b0;
        end else begin
            if (filt[0] == filt[1]) begin
                mis_cnt <= '0;                                  // see R4
            end else if (mis_cnt <= CW'(MISMATCH_CYC)) begin
                mis_cnt <= mis_cnt + CW'(1);
            end
            if (mis_cnt > CW'(MISMATCH_CYC)) begin
                CHANNEL_MISMATCH_ALARM <= 1'b1;                 // see R4, see R5
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            SINGLE_FAULT_ALARM <= 1'b0;
        end else if (fsync2) begin
            SINGLE_FAULT_ALARM <= 1'b1;                         // see R6
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            torque_cutoff_pkg::ST_CUTOFF: begin
                if (both_on) begin
                    next_state = torque_cutoff_pkg::ST_READY;   // see R2
                end
            end
            torque_cutoff_pkg::ST_READY: begin
                if (SERVO_ON) begin
                    next_state = torque_cutoff_pkg::ST_RUN;     // see R11
                end
            end
            torque_cutoff_pkg::ST_RUN: begin
                if (!SERVO_ON) begin
                    next_state = torque_cutoff_pkg::ST_READY;   // see R11
                end
            end
            torque_cutoff_pkg::ST_FAULT: begin
                next_state = torque_cutoff_pkg::ST_FAULT;
            end
        endcase
        // Any channel off leaves no permission to drive torque
        if (state != torque_cutoff_pkg::ST_FAULT && !both_on) begin
            next_state = torque_cutoff_pkg::ST_CUTOFF;          // see R1, see R3
        end
        if (SINGLE_FAULT_ALARM) begin
            next_state = torque_cutoff_pkg::ST_FAULT;           // see R6
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state <= torque_cutoff_pkg::ST_CUTOFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            POWER_STAGE_ENABLE <= 1'b0;
            READY              <= 1'b0;
        end else begin
            POWER_STAGE_ENABLE <= (next_state == torque_cutoff_pkg::ST_RUN);   // see R10
            READY              <= (next_state == torque_cutoff_pkg::ST_READY)
                                | (next_state == torque_cutoff_pkg::ST_RUN);
        end
    end

    property p_both_off_cut;
        @(posedge CLK) disable iff (!RESETN)
        both_off |=> !POWER_STAGE_ENABLE;
    endproperty
    a_both_off_cut: assert property (p_both_off_cut)        // see R1
        else $error("Power stage enabled with both channels off");

    property p_ready_on_both;
        @(posedge CLK) disable iff (!RESETN)
        (state == torque_cutoff_pkg::ST_CUTOFF && both_on && !SINGLE_FAULT_ALARM)
            |=> READY;
    endproperty
    a_ready_on_both: assert property (p_ready_on_both)      // see R2
        else $error("Not ready after both channels on");

    property p_run_cut;
        @(posedge CLK) disable iff (!RESETN)
        (POWER_STAGE_ENABLE && SERVO_ON && !filt[0]) |=> !POWER_STAGE_ENABLE;
    endproperty
    a_run_cut: assert property (p_run_cut)                  // see R3
        else $error("Running continued with a channel off");

    property p_mismatch;
        @(posedge CLK) disable iff (!RESETN)
        (mis_cnt == CW'(MISMATCH_CYC) && filt[0] != filt[1]) |=> ##1 CHANNEL_MISMATCH_ALARM;
    endproperty
    a_mismatch: assert property (p_mismatch)                // see R4
        else $error("Mismatch alarm late");

    property p_mismatch_hold;
        @(posedge CLK) disable iff (!RESETN)
        CHANNEL_MISMATCH_ALARM |=> CHANNEL_MISMATCH_ALARM;
    endproperty
    a_mismatch_hold: assert property (p_mismatch_hold)      // see R5
        else $error("Mismatch alarm cleared without reset");

    property p_fault_cut;
        @(posedge CLK) disable iff (!RESETN)
        fsync2 |=> ##1 (SINGLE_FAULT_ALARM && !POWER_STAGE_ENABLE && !READY);
    endproperty
    a_fault_cut: assert property (p_fault_cut)              // see R6
        else $error("Single fault did not cut output");

    // Cycles since synced channel A went off; saturates just past the filter span
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            off_age <= '0;
        end else if (sync2[0]) begin
            off_age <= '0;
        end else if (off_age <= CW'(FILTER_CYC + 1)) begin
            off_age <= off_age + CW'(1);
        end
    end

    // Filter span plus one state edge is far inside the 50 ms budget
    property p_cutoff_time;
        @(posedge CLK) disable iff (!RESETN)
        (off_age > CW'(FILTER_CYC + 1)) |-> !POWER_STAGE_ENABLE;
    endproperty
    a_cutoff_time: assert property (p_cutoff_time)          // see R10
        else $error("Cutoff not completed in time");

    property p_servo_run;
        @(posedge CLK) disable iff (!RESETN)
        (state == torque_cutoff_pkg::ST_READY && SERVO_ON && both_on && !SINGLE_FAULT_ALARM)
            |=> POWER_STAGE_ENABLE;
    endproperty
    a_servo_run: assert property (p_servo_run)              // see R11
        else $error("Servo-on did not start running");

    property p_short_pulse;
        @(posedge CLK) disable iff (!RESETN)
        (sync2[0] && filt[0]) ##1 !sync2[0] |-> filt[0] [*8];
    endproperty
    a_short_pulse: assert property (p_short_pulse)          // see R12
        else $error("Short off pulse passed filter");
endmodule
`default_nettype wire

/* File: torque_cutoff_pkg.sv */
/*
 * Constants for the dual-channel torque cutoff monitor: timing figures,
 * derived cycle counts and the state encoding.
 * Assumes a single 100 MHz clock.
 */
`default_nettype none
package torque_cutoff_pkg;
    localparam int CLK_HZ           = 100_000_000;
    localparam int TEST_PULSE_US    = 1000;   // Longest test pulse allowed on a channel
    localparam int MISMATCH_MS      = 50;     // Disagreement limit before the alarm
    localparam int CUTOFF_MS        = 50;     // Longest cutoff response
    localparam int FILTER_CYCLES    = (CLK_HZ / 1_000_000) * TEST_PULSE_US;
    localparam int MISMATCH_CYCLES  = (CLK_HZ / 1000) * MISMATCH_MS;
    localparam int CUTOFF_CYCLES    = (CLK_HZ / 1000) * CUTOFF_MS;
    localparam int CNT_W            = 24;

    typedef enum logic [1:0] {
        ST_CUTOFF = 2'h0,
        ST_READY  = 2'h1,
        ST_RUN    = 2'h2,
        ST_FAULT  = 2'h3
    } drive_state_t;
endpackage
`default_nettype wire
